// ===== logic/dsr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Run program once per 8 kHz period
// - Pass completion sets done flag bit 17
// - Masked done flag pulls interrupt pin low
// - Writing one to bit 17 clears flag
// - Data memory 0x4000 to 0x43FF, 28 bits
// - Reset idles processor, zeroes memory, run
// - Writing 0x0001 to run starts execution
// - Writing 0x0000 to run stops processor
// - Writes accepted while processor is running
// - Square, low-pass filter, square root
// - Signed 24-bit rms per phase, 8 kHz
// - Full-scale sine gives 0x3FF6A6
// - Integrator bit 0 changes 60 Hz scale
// - Result settles within about half second
// - Rms read as 32 bits, top zero
// - Offset adds 128 times offset under root
// - Negative root argument yields 0x7FFFFF
// - Offset read top four zero, sign-extended
module dsr_top #(
  parameter int unsigned PASS_CYCLES = dsr_pkg::PASS_CYCLES,
  parameter int unsigned LPF_SHIFT = dsr_pkg::LPF_SHIFT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic [dsr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dsr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dsr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic signed [dsr_pkg::RMS_W-1:0] current_sample_a,
  input wire logic signed [dsr_pkg::RMS_W-1:0] current_sample_b,
  input wire logic signed [dsr_pkg::RMS_W-1:0] current_sample_c,
  output logic first_interrupt_pin_n,
  output logic integrator_enable_bit,
  output logic dsp_running
);
  localparam int unsigned CNT_W = $clog2(PASS_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PASS_CYCLES - 1);
  localparam dsr_pkg::dsr_phase_t LAST_PHASE = dsr_pkg::PHASE_W'(dsr_pkg::NUM_PHASES - 1);
  localparam int unsigned ARG_W = dsr_pkg::SQ_W + 2;

  // ==========================================================
  // Address decode
  function automatic logic in_dmem(input dsr_pkg::dsr_addr_t a);
    return (a >= dsr_pkg::DMEM_FIRST) && (a <= dsr_pkg::DMEM_LAST);
  endfunction : in_dmem

  function automatic logic in_block(input dsr_pkg::dsr_addr_t a,
                                    input dsr_pkg::dsr_addr_t base);
    return (a >= base) && (a < base + dsr_pkg::ADDR_W'(dsr_pkg::NUM_PHASES));
  endfunction : in_block

  function automatic dsr_pkg::dsr_phase_t block_index(input dsr_pkg::dsr_addr_t a,
                                                      input dsr_pkg::dsr_addr_t base);
    dsr_pkg::dsr_addr_t d;
    d = a - base;
    return d[dsr_pkg::PHASE_W-1:0];
  endfunction : block_index

  // ==========================================================
  // Control registers
  logic rst;
  logic [dsr_pkg::RUN_W-1:0] run_reg, next_run_reg;
  logic [dsr_pkg::DATA_W-1:0] mask_reg, next_mask_reg;
  logic [dsr_pkg::CFG_W-1:0] config_reg, next_config_reg;
  logic done_flag, next_done_flag;
  logic running;
  logic start_pulse;
  logic status_clear;
  logic pass_done;

  assign rst = reset | soft_reset;
  assign running = (run_reg == dsr_pkg::RUN_START);
  assign start_pulse = reg_wr && (reg_addr == dsr_pkg::RUN_ADDR) && !running &&
                       (reg_wdata[dsr_pkg::RUN_W-1:0] == dsr_pkg::RUN_START);
  assign status_clear = reg_wr && (reg_addr == dsr_pkg::FIRST_STATUS_WORD_ADDR) &&
                        reg_wdata[dsr_pkg::DONE_BIT];

  always_comb begin
    next_run_reg = run_reg;
    next_mask_reg = mask_reg;
    next_config_reg = config_reg;
    if (reg_wr) begin
      if (reg_addr == dsr_pkg::RUN_ADDR) begin
        next_run_reg = reg_wdata[dsr_pkg::RUN_W-1:0];
      end else if (reg_addr == dsr_pkg::FIRST_INTERRUPT_MASK_ADDR) begin
        next_mask_reg = reg_wdata;
      end else if (reg_addr == dsr_pkg::CONFIG_ADDR) begin
        next_config_reg = reg_wdata[dsr_pkg::CFG_W-1:0];
      end
    end
    next_done_flag = pass_done | (done_flag & ~status_clear);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= dsr_pkg::RUN_RESET;
      mask_reg <= '0;
      config_reg <= '0;
      done_flag <= 1'b0;
    end else begin
      run_reg <= next_run_reg;
      mask_reg <= next_mask_reg;
      config_reg <= next_config_reg;
      done_flag <= next_done_flag;
    end
  end

  assign first_interrupt_pin_n = ~(done_flag & mask_reg[dsr_pkg::DONE_BIT]);
  assign integrator_enable_bit = config_reg[dsr_pkg::INTEGRATOR_BIT];
  assign dsp_running = running;

  // ==========================================================
  // Pass timer
  logic [CNT_W-1:0] pass_cnt, next_pass_cnt;
  logic tick;

  assign tick = running && (pass_cnt == CNT_LAST);

  always_comb begin
    if (start_pulse) begin
      next_pass_cnt = CNT_LAST;
    end else if (!running || (pass_cnt == CNT_LAST)) begin
      next_pass_cnt = '0;
    end else begin
      next_pass_cnt = pass_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pass_cnt <= '0;
    end else begin
      pass_cnt <= next_pass_cnt;
    end
  end

  // ==========================================================
  // Per-phase storage
  logic signed [dsr_pkg::RMS_W-1:0] sample_in [dsr_pkg::NUM_PHASES];
  logic signed [dsr_pkg::RMS_W-1:0] sample [dsr_pkg::NUM_PHASES];
  logic signed [dsr_pkg::RMS_W-1:0] next_sample [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_word_t offset [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_word_t next_offset [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_sq_t ms [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_sq_t next_ms [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_rms_t rms [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_rms_t next_rms [dsr_pkg::NUM_PHASES];
  dsr_pkg::dsr_state_e state, next_state;
  dsr_pkg::dsr_phase_t phase, next_phase;
  dsr_pkg::dsr_sq_t ms_update;
  dsr_pkg::dsr_rms_t rms_value;
  logic rms_load;
  logic offset_wr;
  dsr_pkg::dsr_phase_t offset_idx;

  assign sample_in[0] = current_sample_a;
  assign sample_in[1] = current_sample_b;
  assign sample_in[2] = current_sample_c;
  assign offset_wr = reg_wr && in_block(reg_addr, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE);
  assign offset_idx = block_index(reg_addr, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE);

  for (genvar p = 0; p < dsr_pkg::NUM_PHASES; p++) begin : g_phase
    always_comb begin
      next_sample[p] = tick ? sample_in[p] : sample[p];
      next_offset[p] = offset[p];
      next_ms[p] = ms[p];
      next_rms[p] = rms[p];
      if (offset_wr && (offset_idx == dsr_pkg::PHASE_W'(p))) begin
        next_offset[p] = dsr_pkg::WORD_W'($signed(reg_wdata[dsr_pkg::RMS_W-1:0]));
      end
      if ((state == dsr_pkg::ST_SQUARE) && (phase == dsr_pkg::PHASE_W'(p))) begin
        next_ms[p] = ms_update;
      end
      if (rms_load && (phase == dsr_pkg::PHASE_W'(p))) begin
        next_rms[p] = rms_value;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        sample[p] <= '0;
        offset[p] <= '0;
        ms[p] <= '0;
        rms[p] <= '0;
      end else begin
        sample[p] <= next_sample[p];
        offset[p] <= next_offset[p];
        ms[p] <= next_ms[p];
        rms[p] <= next_rms[p];
      end
    end
  end

  // ==========================================================
  // Square, filter and root argument
  logic signed [dsr_pkg::SQ_W:0] ms_delta;
  logic signed [dsr_pkg::SQ_W:0] ms_sum;
  logic signed [ARG_W-1:0] root_arg;
  logic signed [dsr_pkg::SQ_W-1:0] sq_in;
  dsr_pkg::dsr_sq_t square;

  always_comb begin
    sq_in = dsr_pkg::SQ_W'(sample[phase]);
    square = sq_in * sq_in;
    ms_delta = $signed({1'b0, square}) - $signed({1'b0, ms[phase]});
    ms_sum = $signed({1'b0, ms[phase]}) + (ms_delta >>> LPF_SHIFT);
    ms_update = ms_sum[dsr_pkg::SQ_W-1:0];
    root_arg = $signed({2'b00, ms[phase]}) +
               ($signed(ARG_W'($signed(offset[phase]))) <<< dsr_pkg::OFFSET_SHIFT);
  end

  // ==========================================================
  // Pass sequencer
  dsr_sqrt_if sq_bus ();

  dsr_isqrt u_isqrt (
    .clk(clk),
    .reset(rst),
    .sq(sq_bus)
  );

  assign sq_bus.radicand = root_arg[dsr_pkg::SQ_W-1:0];

  always_comb begin
    next_state = state;
    next_phase = phase;
    sq_bus.start = 1'b0;
    rms_load = 1'b0;
    rms_value = sq_bus.root;
    pass_done = 1'b0;
    if (!running) begin
      next_state = dsr_pkg::ST_IDLE;
    end else begin
      case (state)
        dsr_pkg::ST_IDLE: begin
          if (tick) begin
            next_state = dsr_pkg::ST_SQUARE;
            next_phase = '0;
          end
        end
        dsr_pkg::ST_SQUARE: begin
          next_state = dsr_pkg::ST_ARG;
        end
        dsr_pkg::ST_ARG: begin
          if (root_arg[ARG_W-1]) begin
            rms_load = 1'b1;
            rms_value = dsr_pkg::RMS_ERROR;
            next_state = dsr_pkg::ST_NEXT;
          end else begin
            sq_bus.start = 1'b1;
            next_state = dsr_pkg::ST_ROOT;
          end
        end
        dsr_pkg::ST_ROOT: begin
          if (sq_bus.done) begin
            rms_load = 1'b1;
            next_state = dsr_pkg::ST_NEXT;
          end
        end
        dsr_pkg::ST_NEXT: begin
          if (phase == LAST_PHASE) begin
            pass_done = 1'b1;
            next_state = dsr_pkg::ST_IDLE;
          end else begin
            next_phase = phase + 1'b1;
            next_state = dsr_pkg::ST_SQUARE;
          end
        end
        default: begin
          next_state = dsr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= dsr_pkg::ST_IDLE;
      phase <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  // ==========================================================
  // Data memory
  dsr_pkg::dsr_word_t dmem [dsr_pkg::DMEM_DEPTH];
  logic [dsr_pkg::DMEM_DEPTH-1:0] dmem_valid, next_dmem_valid;
  logic dmem_we;
  logic [dsr_pkg::DMEM_IDX_W-1:0] dmem_idx;

  assign dmem_idx = reg_addr[dsr_pkg::DMEM_IDX_W-1:0];
  assign dmem_we = reg_wr && in_dmem(reg_addr) &&
                   !in_block(reg_addr, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE) &&
                   !in_block(reg_addr, dsr_pkg::IRMS_BASE);

  always_comb begin
    next_dmem_valid = dmem_valid;
    if (dmem_we) begin
      next_dmem_valid[dmem_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dmem_valid <= '0;
    end else begin
      dmem_valid <= next_dmem_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (dmem_we) begin
      dmem[dmem_idx] <= reg_wdata[dsr_pkg::WORD_W-1:0];
    end
  end

  // ==========================================================
  // Read port
  logic [dsr_pkg::DATA_W-1:0] next_rdata;
  dsr_pkg::dsr_phase_t rms_idx;

  assign rms_idx = block_index(reg_addr, dsr_pkg::IRMS_BASE);

  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == dsr_pkg::RUN_ADDR) begin
        next_rdata = dsr_pkg::DATA_W'(run_reg);
      end else if (reg_addr == dsr_pkg::FIRST_STATUS_WORD_ADDR) begin
        next_rdata = dsr_pkg::DATA_W'(done_flag) << dsr_pkg::DONE_BIT;
      end else if (reg_addr == dsr_pkg::FIRST_INTERRUPT_MASK_ADDR) begin
        next_rdata = mask_reg;
      end else if (reg_addr == dsr_pkg::CONFIG_ADDR) begin
        next_rdata = dsr_pkg::DATA_W'(config_reg);
      end else if (in_block(reg_addr, dsr_pkg::IRMS_BASE)) begin
        next_rdata = dsr_pkg::DATA_W'(rms[rms_idx]);
      end else if (in_block(reg_addr, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE)) begin
        next_rdata = dsr_pkg::DATA_W'(offset[offset_idx]);
      end else if (in_dmem(reg_addr)) begin
        if (dmem_valid[dmem_idx]) begin
          next_rdata = dsr_pkg::DATA_W'(dmem[dmem_idx]);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= reg_rd;
    end
  end
endmodule : dsr_top

// ===== logic/dsr_pkg.sv
package dsr_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PASS_RATE_HZ = 8_000;
  localparam int unsigned PASS_CYCLES = CLK_HZ / PASS_RATE_HZ;
  localparam int unsigned LPF_SHIFT = 9;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RUN_W = 16;
  localparam int unsigned CFG_W = 16;
  localparam int unsigned WORD_W = 28;
  localparam int unsigned RMS_W = 24;
  localparam int unsigned SQ_W = 48;
  localparam int unsigned NUM_PHASES = 3;
  localparam int unsigned PHASE_W = 2;
  localparam int unsigned DMEM_IDX_W = 10;
  localparam int unsigned DMEM_DEPTH = 1024;
  localparam int unsigned SQRT_CNT_W = 5;

  typedef logic [ADDR_W-1:0] dsr_addr_t;
  typedef logic [WORD_W-1:0] dsr_word_t;
  typedef logic [RMS_W-1:0] dsr_rms_t;
  typedef logic [SQ_W-1:0] dsr_sq_t;
  typedef logic [PHASE_W-1:0] dsr_phase_t;

  // ==========================================================
  // Register map
  localparam dsr_addr_t DMEM_FIRST = 16'h4000;
  localparam dsr_addr_t DMEM_LAST = 16'h43FF;
  localparam dsr_addr_t CURRENT_RMS_OFFSET_VALUE_BASE = 16'h4380;
  localparam dsr_addr_t IRMS_BASE = 16'h43C0;
  localparam dsr_addr_t RUN_ADDR = 16'hE000;
  localparam dsr_addr_t FIRST_STATUS_WORD_ADDR = 16'hE100;
  localparam dsr_addr_t FIRST_INTERRUPT_MASK_ADDR = 16'hE104;
  localparam dsr_addr_t CONFIG_ADDR = 16'hE108;

  // ==========================================================
  // Fields and codes
  localparam logic [RUN_W-1:0] RUN_START = 16'h0001;
  localparam logic [RUN_W-1:0] RUN_RESET = 16'h0000;
  localparam int unsigned DONE_BIT = 17;
  localparam int unsigned INTEGRATOR_BIT = 0;
  localparam int unsigned OFFSET_SHIFT = 7;
  localparam dsr_rms_t RMS_ERROR = 24'h7F_FFFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SQUARE = 3'b001,
    ST_ARG = 3'b010,
    ST_ROOT = 3'b011,
    ST_NEXT = 3'b100
  } dsr_state_e;
endpackage : dsr_pkg

// ===== logic/dsr_sqrt_if.sv
`timescale 1ns/1ps
interface dsr_sqrt_if;
  logic start;
  dsr_pkg::dsr_sq_t radicand;
  logic done;
  dsr_pkg::dsr_rms_t root;
  modport client (output start, output radicand, input done, input root);
  modport server (input start, input radicand, output done, output root);
endinterface : dsr_sqrt_if

// ===== logic/dsr_isqrt.sv
`timescale 1ns/1ps
module dsr_isqrt (
  input wire logic clk,
  input wire logic reset,
  dsr_sqrt_if.server sq
);
  localparam int unsigned REM_W = dsr_pkg::RMS_W + 3;
  localparam logic [dsr_pkg::SQRT_CNT_W-1:0] LAST_STEP =
    dsr_pkg::SQRT_CNT_W'(dsr_pkg::RMS_W - 1);

  // ==========================================================
  // Restoring square root, two radicand bits per step
  logic busy, next_busy;
  logic done_q, next_done_q;
  logic [dsr_pkg::SQRT_CNT_W-1:0] step, next_step;
  dsr_pkg::dsr_sq_t rad, next_rad;
  logic [REM_W-1:0] rem, next_rem;
  dsr_pkg::dsr_rms_t root, next_root;
  logic [REM_W-1:0] rem_try;
  logic [REM_W-1:0] trial;

  always_comb begin
    rem_try = {rem[REM_W-3:0], rad[dsr_pkg::SQ_W-1 -: 2]};
    trial = {1'b0, root, 2'b01};
    next_busy = busy;
    next_done_q = 1'b0;
    next_step = step;
    next_rad = rad;
    next_rem = rem;
    next_root = root;
    if (sq.start) begin
      next_busy = 1'b1;
      next_step = '0;
      next_rad = sq.radicand;
      next_rem = '0;
      next_root = '0;
    end else if (busy) begin
      next_rad = {rad[dsr_pkg::SQ_W-3:0], 2'b00};
      if (rem_try >= trial) begin
        next_rem = rem_try - trial;
        next_root = {root[dsr_pkg::RMS_W-2:0], 1'b1};
      end else begin
        next_rem = rem_try;
        next_root = {root[dsr_pkg::RMS_W-2:0], 1'b0};
      end
      next_step = step + 1'b1;
      if (step == LAST_STEP) begin
        next_busy = 1'b0;
        next_done_q = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      done_q <= 1'b0;
      step <= '0;
      rad <= '0;
      rem <= '0;
      root <= '0;
    end else begin
      busy <= next_busy;
      done_q <= next_done_q;
      step <= next_step;
      rad <= next_rad;
      rem <= next_rem;
      root <= next_root;
    end
  end

  assign sq.done = done_q;
  assign sq.root = root;
endmodule : dsr_isqrt

// ===== testbench/dsr_top_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks for the sequencer top
module dsr_top_checker #(
  parameter int unsigned PASS_CYCLES = 200,
  parameter int unsigned LPF_SHIFT = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic signed [23:0] current_sample_a,
  input wire logic signed [23:0] current_sample_b,
  input wire logic signed [23:0] current_sample_c,
  input wire logic first_interrupt_pin_n,
  input wire logic integrator_enable_bit,
  input wire logic dsp_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic wr_ok;
  assign wr_ok = reg_wr && !soft_reset;

  property p_rvalid;
    reg_rvalid == $past(reg_rd && !soft_reset && !reset);
  endproperty
  property p_rms_pad;
    reg_rvalid && $past(reg_addr) >= dsr_pkg::IRMS_BASE
      && $past(reg_addr) <= dsr_pkg::IRMS_BASE + 2 |-> reg_rdata[31:24] == 8'h00;
  endproperty
  property p_os_pad;
    reg_rvalid && $past(reg_addr) >= dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE
      && $past(reg_addr) <= dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 2
      |-> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}};
  endproperty
  property p_mem_width;
    reg_rvalid && $past(reg_addr) >= dsr_pkg::DMEM_FIRST
      && $past(reg_addr) <= dsr_pkg::DMEM_LAST |-> reg_rdata[31:28] == 4'h0;
  endproperty
  property p_start;
    wr_ok && reg_addr == dsr_pkg::RUN_ADDR && reg_wdata[15:0] == dsr_pkg::RUN_START
      |=> dsp_running;
  endproperty
  property p_stop;
    wr_ok && reg_addr == dsr_pkg::RUN_ADDR && reg_wdata[15:0] != dsr_pkg::RUN_START
      |=> !dsp_running [*2];
  endproperty
  property p_soft;
    soft_reset |=> !dsp_running && first_interrupt_pin_n && !reg_rvalid
      && !integrator_enable_bit;
  endproperty
  property p_irq_cause;
    $fell(first_interrupt_pin_n)
      |-> $past(dsp_running) || $past(reg_wr && reg_addr == dsr_pkg::FIRST_INTERRUPT_MASK_ADDR);
  endproperty
  property p_clear;
    wr_ok && reg_addr == dsr_pkg::FIRST_STATUS_WORD_ADDR && reg_wdata[dsr_pkg::DONE_BIT]
      && !dsp_running |=> first_interrupt_pin_n;
  endproperty
  property p_mask_off;
    wr_ok && reg_addr == dsr_pkg::FIRST_INTERRUPT_MASK_ADDR && !reg_wdata[dsr_pkg::DONE_BIT]
      |=> first_interrupt_pin_n [*2];
  endproperty
  property p_integ;
    wr_ok && reg_addr == dsr_pkg::CONFIG_ADDR
      |=> integrator_enable_bit == $past(reg_wdata[dsr_pkg::INTEGRATOR_BIT]);
  endproperty

  a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
  a_rms_pad: assert property (p_rms_pad) else $error("rms read not padded");
  a_os_pad: assert property (p_os_pad) else $error("offset read not extended");
  a_mem_width: assert property (p_mem_width) else $error("memory word too wide");
  a_start: assert property (p_start) else $error("start write ignored");
  a_stop: assert property (p_stop) else $error("stop write ignored");
  a_soft: assert property (p_soft) else $error("soft reset not idle");
  a_irq_cause: assert property (p_irq_cause) else $error("irq while stopped");
  a_clear: assert property (p_clear) else $error("irq not cleared");
  a_mask_off: assert property (p_mask_off) else $error("masked irq active");
  a_integ: assert property (p_integ) else $error("integrator bit wrong");

  c_pass_done: cover property ($fell(first_interrupt_pin_n) && dsp_running);
  c_err_read: cover property (reg_rvalid && reg_rdata == 32'h007F_FFFF);
  c_soft: cover property (soft_reset);
endmodule : dsr_top_checker

// ===== testbench/dsr_top_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the sequencer top
module dsr_top_tb_top;
  localparam int unsigned PC = 200;
  localparam logic [31:0] DONE = 32'h0002_0000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic soft_reset = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic signed [23:0] sample_a = 24'h00_0000;
  logic signed [23:0] sample_b = 24'h00_0000;
  logic signed [23:0] sample_c = 24'h00_0000;
  logic signed [23:0] mag_a = 24'h00_0000;
  logic irq_n;
  logic integ;
  logic running;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1;
  int t2;
  logic [31:0] exp_q[$];
  logic [31:0] tol_q[$];
  logic [15:0] zero_addr[11] = '{dsr_pkg::RUN_ADDR, dsr_pkg::FIRST_STATUS_WORD_ADDR,
    dsr_pkg::FIRST_INTERRUPT_MASK_ADDR, dsr_pkg::CONFIG_ADDR, dsr_pkg::DMEM_FIRST,
    dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h1, dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h2,
    dsr_pkg::IRMS_BASE, dsr_pkg::IRMS_BASE + 16'h1, dsr_pkg::IRMS_BASE + 16'h2};

  dsr_top #(.PASS_CYCLES(PC), .LPF_SHIFT(2)) DUT (
    .clk(clk), .reset(reset), .soft_reset(soft_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .current_sample_a(sample_a), .current_sample_b(sample_b),
    .current_sample_c(sample_c), .first_interrupt_pin_n(irq_n),
    .integrator_enable_bit(integ), .dsp_running(running));

  // ==========================================================
  // Clock, samples, read monitor, watchdog
  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    sample_a <= ($urandom() % 2 == 0) ? mag_a : -mag_a;
  end

  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error read answer expected none seen %h", reg_rdata);
      end else begin
        chk_rd(exp_q.pop_front(), tol_q.pop_front(), reg_rdata);
      end
    end
  end

  initial begin
    repeat (50_000) @(posedge clk);
    fails++;
    wrap_up();
  end

  // ==========================================================
  // Tasks
  task automatic chk_rd(input logic [31:0] e, input logic [31:0] t, input logic [31:0] s);
    n_checks++;
    if ($isunknown(s) || s > e || s + t < e) begin
      fails++;
      $display("Error read data expected %h seen %h", e, s);
    end
  endtask : chk_rd

  task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask : chk_val

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] t);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    tol_q.push_back(t);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wait_low(output int t);
    int k;
    k = 0;
    @(negedge clk);
    while (irq_n !== 1'b0 && k < 4 * PC) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4 * PC) fails++;
    t = cyc;
  endtask : wait_low

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h2e73_f228));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    foreach (zero_addr[i]) rd(zero_addr[i], 0, 0);
    wr(16'h4123, 32'hFFFF_FFFF);
    rd(16'h4123, 32'h0FFF_FFFF, 0);
    wr(dsr_pkg::DMEM_LAST, 32'h0ABC_DEF1);
    rd(dsr_pkg::DMEM_LAST, 32'h0ABC_DEF1, 0);
    wr(16'h4400, 32'h0000_1234);
    rd(16'h4400, 0, 0);
    wr(dsr_pkg::IRMS_BASE, 32'h0000_0123);
    rd(dsr_pkg::IRMS_BASE, 0, 0);
    wr(dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h1, 32'h0000_0002);
    rd(dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h1, 32'h0000_0002, 0);
    wr(dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h2, 32'h00FF_FFFF);
    rd(dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h2, 32'h0FFF_FFFF, 0);
    wr(dsr_pkg::CONFIG_ADDR, 32'h0000_0001);
    rd(dsr_pkg::CONFIG_ADDR, 32'h0000_0001, 0);
    @(negedge clk);
    chk_val("integrator", 1, integ);
    wr(dsr_pkg::CONFIG_ADDR, 32'h0000_0000);
    wr(dsr_pkg::FIRST_INTERRUPT_MASK_ADDR, DONE);
    mag_a <= 24'sd1000;
    wr(dsr_pkg::RUN_ADDR, 32'h0000_0001);
    wait_low(t1);
    wr(dsr_pkg::FIRST_STATUS_WORD_ADDR, DONE);
    wait_low(t2);
    chk_val("pass period", PC, t2 - t1);
    wr(16'h4010, 32'h0000_0055);
    rd(16'h4010, 32'h0000_0055, 0);
    repeat (60 * PC) @(posedge clk);
    rd(dsr_pkg::IRMS_BASE, 32'd1000, 2);
    rd(dsr_pkg::IRMS_BASE + 16'h1, 32'd16, 0);
    rd(dsr_pkg::IRMS_BASE + 16'h2, 32'h007F_FFFF, 0);
    rd(dsr_pkg::FIRST_STATUS_WORD_ADDR, DONE, 0);
    wr(dsr_pkg::FIRST_STATUS_WORD_ADDR, DONE);
    @(negedge clk);
    chk_val("irq pin", 1, irq_n);
    wr(dsr_pkg::FIRST_INTERRUPT_MASK_ADDR, 0);
    repeat (PC + 10) @(posedge clk);
    @(negedge clk);
    chk_val("irq pin", 1, irq_n);
    rd(dsr_pkg::FIRST_STATUS_WORD_ADDR, DONE, 0);
    wr(dsr_pkg::FIRST_INTERRUPT_MASK_ADDR, DONE);
    @(negedge clk);
    chk_val("irq pin", 0, irq_n);
    wr(dsr_pkg::RUN_ADDR, 0);
    wr(dsr_pkg::FIRST_STATUS_WORD_ADDR, DONE);
    mag_a <= 24'sd0;
    repeat (3 * PC) @(posedge clk);
    @(negedge clk);
    chk_val("running", 0, running);
    chk_val("irq pin", 1, irq_n);
    rd(dsr_pkg::IRMS_BASE, 32'd1000, 2);
    rd(dsr_pkg::FIRST_STATUS_WORD_ADDR, 0, 0);
    wr(dsr_pkg::RUN_ADDR, 32'h0000_0001);
    wr(dsr_pkg::RUN_ADDR, 32'h0000_0002);
    @(negedge clk);
    chk_val("running", 0, running);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(dsr_pkg::CURRENT_RMS_OFFSET_VALUE_BASE + 16'h2, 0, 0);
    rd(16'h4123, 0, 0);
    rd(dsr_pkg::IRMS_BASE, 0, 0);
    repeat (4) @(posedge clk);
    chk_val("pending reads", 0, exp_q.size());
    wrap_up();
  end
endmodule : dsr_top_tb_top

bind dsr_top dsr_top_checker #(.PASS_CYCLES(PASS_CYCLES), .LPF_SHIFT(LPF_SHIFT)) u_chk (
  .clk(clk), .reset(reset), .soft_reset(soft_reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .current_sample_a(current_sample_a),
  .current_sample_b(current_sample_b), .current_sample_c(current_sample_c),
  .first_interrupt_pin_n(first_interrupt_pin_n),
  .integrator_enable_bit(integrator_enable_bit), .dsp_running(dsp_running));
